// [inc/quadrature_decoder_pkg.sv]
// Package with register map, field positions and reset values of the quadrature decoder
`default_nettype none
package quadrature_decoder_pkg;
   // Register offsets (byte addresses)
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] POS_OFS = 8'h08;
   localparam logic [7:0] MAXPOS_OFS = 8'h0C;
   localparam logic [7:0] LOAD_OFS = 8'h10;
   localparam logic [7:0] TIME_OFS = 8'h14;
   localparam logic [7:0] COUNT_OFS = 8'h18;
   localparam logic [7:0] SPEED_OFS = 8'h1C;
   localparam logic [7:0] INTEN_OFS = 8'h20;
   localparam logic [7:0] RIS_OFS = 8'h24;
   localparam logic [7:0] ISC_OFS = 8'h28;
   localparam logic [7:0] PREDIV_OFS = 8'h2C;
   // Control register fields
   localparam int CTRL_EN = 0;
   localparam int CTRL_SWAP = 1;
   localparam int CTRL_SIGMODE = 2;
   localparam int CTRL_CAPMODE = 3;
   localparam int CTRL_RESMODE = 4;
   localparam int CTRL_VELEN = 5;
   localparam int CTRL_W = 6;
   // Status fields
   localparam int STAT_ERR = 0;
   localparam int STAT_DIR = 1;
   // Interrupt bit positions
   localparam int INT_INDEX = 0;
   localparam int INT_TIMER = 1;
   localparam int INT_DIR = 2;
   localparam int INT_ERROR = 3;
   localparam int INT_W = 4;
   // Reset values and common constants
   localparam logic [31:0] MAXPOS_RST = 32'hFFFF_FFFF;
   localparam logic [31:0] LOAD_RST = 32'h0000_FFFF;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   localparam logic [31:0] ONE32 = 32'h0000_0001;
endpackage
`default_nettype wire

// [src/input_sync.sv]
// Three-stage synchroniser with agreement filter for one pin
`default_nettype none
module input_sync
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // Pin and filtered level
   input wire logic pin_in,
   output logic level_out
);
   logic s1_q, s2_q, s3_q, lvl_q, lvl_d;

   // New level only once stages two and three agree
   always_comb
   begin
      lvl_d = lvl_q;
      if (s2_q == s3_q)
      begin
         lvl_d = s3_q;
      end
   end

   // Register chain
   always_ff @(posedge sys_clk_in)
   begin
      if (!reset_n_in)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         lvl_q <= 1'b0;
      end
      else
      begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign level_out = lvl_q;
endmodule
`default_nettype wire

// [src/sticky_flag.sv]
// Sticky status bit with write-one-to-clear, set wins over clear
`default_nettype none
module sticky_flag
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // Event and clear
   input wire logic set_in,
   input wire logic clear_in,
   output logic flag_out
);
   logic flag_q, flag_d;

   // Set has priority over a clear in the same cycle
   always_comb
   begin
      flag_d = flag_q;
      if (clear_in)
      begin
         flag_d = 1'b0;
      end
      if (set_in)
      begin
         flag_d = 1'b1;
      end
   end

   // Flag register
   always_ff @(posedge sys_clk_in)
   begin
      if (!reset_n_in)
      begin
         flag_q <= 1'b0;
      end
      else
      begin
         flag_q <= flag_d;
      end
   end

   assign flag_out = flag_q;
endmodule
`default_nettype wire

// [src/quadrature_decoder.sv]
// Quadrature decoder: position, velocity, direction and interrupts
//
// Our own choices: the strobed register port and the register addresses.
`default_nettype none
module quadrature_decoder
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // Encoder pins
   input wire logic cha_in,
   input wire logic chb_in,
   input wire logic index_in,
   // Register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // Interrupt
   output logic irq_out
);
   import quadrature_decoder_pkg::*;

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic a_pin, b_pin, idx_pin;
   input_sync u_sync_a (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .pin_in(cha_in), .level_out(a_pin));
   input_sync u_sync_b (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .pin_in(chb_in), .level_out(b_pin));
   input_sync u_sync_i (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .pin_in(index_in),
      .level_out(idx_pin));

   // ****************************************
   // Register state
   // ****************************************
   logic [CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [31:0] maxpos_q, maxpos_d;
   logic [31:0] load_q, load_d;
   logic [31:0] prediv_q, prediv_d;
   logic [INT_W-1:0] inten_q, inten_d;
   logic [31:0] rdata_q, rdata_d;

   // ****************************************
   // Decoder state
   // ****************************************
   logic a_prev_q, a_prev_d, b_prev_q, b_prev_d, idx_prev_q, idx_prev_d;
   logic dir_q, dir_d, err_q, err_d;
   logic [31:0] pos_q, pos_d;
   logic [31:0] timer_q, timer_d, pre_q, pre_d;
   logic [31:0] count_q, count_d, speed_q, speed_d;

   // Event strobes
   logic ev_index, ev_timer, ev_dir, ev_error;
   logic [INT_W-1:0] ev_vec, ris, clr_vec;

   // Decode helpers
   logic en, ca, cb, pa, pb, a_chg, b_chg, step, step_dir, idx_rise;

   // Swap channels and detect edges
   always_comb
   begin
      en = ctrl_q[CTRL_EN];
      ca = ctrl_q[CTRL_SWAP] ? b_pin : a_pin;
      cb = ctrl_q[CTRL_SWAP] ? a_pin : b_pin;
      // History holds raw pins, so flipping the swap bit makes no false edge
      pa = ctrl_q[CTRL_SWAP] ? b_prev_q : a_prev_q;
      pb = ctrl_q[CTRL_SWAP] ? a_prev_q : b_prev_q;
      a_chg = ca ^ pa;
      b_chg = cb ^ pb;
      idx_rise = idx_pin & ~idx_prev_q;
      step = 1'b0;
      step_dir = dir_q;
      if (ctrl_q[CTRL_SIGMODE])
      begin
         // Clock plus direction: cha steps, chb gives direction
         step = ca & ~pa;
         step_dir = ~cb;
      end
      else if (a_chg ^ b_chg)
      begin
         // Forward when b leads a: a edge to match b
         if (a_chg)
         begin
            step_dir = (ca ^ cb) ? 1'b0 : 1'b1;
            step = 1'b1;
         end
         else
         begin
            step_dir = (ca ^ cb) ? 1'b1 : 1'b0;
            step = ctrl_q[CTRL_CAPMODE];
         end
      end
      step = step & en;
   end

   // Position, direction and error tracking
   always_comb
   begin
      a_prev_d = a_pin;
      b_prev_d = b_pin;
      idx_prev_d = idx_pin;
      pos_d = pos_q;
      dir_d = dir_q;
      err_d = err_q;
      ev_dir = 1'b0;
      ev_error = 1'b0;
      ev_index = 1'b0;
      // Software clear first, so a fault in the same cycle still sets the flag
      if (wr_in && addr_in == STAT_OFS && wdata_in[STAT_ERR])
      begin
         err_d = 1'b0;
      end
      // In quadrature mode both channels moving in one sample is a fault and never counts
      if (en && !ctrl_q[CTRL_SIGMODE] && a_chg && b_chg)
      begin
         err_d = 1'b1;
         ev_error = 1'b1;
      end
      if (step)
      begin
         dir_d = step_dir;
         ev_dir = (step_dir != dir_q);
         if (step_dir)
         begin
            pos_d = (pos_q >= maxpos_q) ? ZERO32 : pos_q + ONE32;
         end
         else
         begin
            pos_d = (pos_q == ZERO32) ? maxpos_q : pos_q - ONE32;
         end
      end
      // Index reload follows the direction of this cycle
      if (en && idx_rise)
      begin
         ev_index = 1'b1;
         if (ctrl_q[CTRL_RESMODE])
         begin
            pos_d = dir_d ? ZERO32 : maxpos_q;
         end
      end
      // A software write to the position wins over counting
      if (wr_in && addr_in == POS_OFS)
      begin
         pos_d = wdata_in;
      end
   end

   // Velocity timer and pulse accumulation
   always_comb
   begin
      timer_d = timer_q;
      pre_d = pre_q;
      count_d = count_q;
      speed_d = speed_q;
      ev_timer = 1'b0;
      if (en && ctrl_q[CTRL_VELEN])
      begin
         if (step)
         begin
            count_d = count_q + ONE32;
         end
         // Prescaler ticks once every prediv plus one cycles
         if (pre_q >= prediv_q)
         begin
            pre_d = ZERO32;
            if (timer_q == ZERO32)
            begin
               timer_d = load_q;
               speed_d = count_d;
               count_d = ZERO32;
               ev_timer = 1'b1;
            end
            else
            begin
               timer_d = timer_q - ONE32;
            end
         end
         else
         begin
            pre_d = pre_q + ONE32;
         end
      end
      else
      begin
         // Stopped: hold the reload value so a new period starts clean
         timer_d = load_q;
         pre_d = ZERO32;
      end
   end

   // Position, direction and error registers
   always_ff @(posedge sys_clk_in)
   begin
      if (!reset_n_in)
      begin
         a_prev_q <= 1'b0;
         b_prev_q <= 1'b0;
         idx_prev_q <= 1'b0;
         dir_q <= 1'b1;
         err_q <= 1'b0;
         pos_q <= ZERO32;
      end
      else
      begin
         a_prev_q <= a_prev_d;
         b_prev_q <= b_prev_d;
         idx_prev_q <= idx_prev_d;
         dir_q <= dir_d;
         err_q <= err_d;
         pos_q <= pos_d;
      end
   end

   // Velocity registers
   always_ff @(posedge sys_clk_in)
   begin
      if (!reset_n_in)
      begin
         timer_q <= ZERO32;
         pre_q <= ZERO32;
         count_q <= ZERO32;
         speed_q <= ZERO32;
      end
      else
      begin
         timer_q <= timer_d;
         pre_q <= pre_d;
         count_q <= count_d;
         speed_q <= speed_d;
      end
   end

   // ****************************************
   // Interrupt status
   // ****************************************
   assign ev_vec = {ev_error, ev_dir, ev_timer, ev_index};
   assign clr_vec = (wr_in && addr_in == ISC_OFS) ? wdata_in[INT_W-1:0] : '0;

   // One sticky bit per source
   genvar gi;
   generate
      for (gi = 0; gi < INT_W; gi++)
      begin : g_flag
         sticky_flag u_flag
         (
            .sys_clk_in(sys_clk_in),
            .reset_n_in(reset_n_in),
            .set_in(ev_vec[gi]),
            .clear_in(clr_vec[gi]),
            .flag_out(ris[gi])
         );
      end
   endgenerate

   // Masked sources drive the interrupt
   assign irq_out = |(ris & inten_q);

   // ****************************************
   // Register writes and reads
   // ****************************************
   always_comb
   begin
      ctrl_d = ctrl_q;
      maxpos_d = maxpos_q;
      load_d = load_q;
      prediv_d = prediv_q;
      inten_d = inten_q;
      rdata_d = ZERO32;
      if (wr_in)
      begin
         case (addr_in)
            CTRL_OFS: ctrl_d = wdata_in[CTRL_W-1:0];
            MAXPOS_OFS: maxpos_d = wdata_in;
            LOAD_OFS: load_d = wdata_in;
            PREDIV_OFS: prediv_d = wdata_in;
            INTEN_OFS: inten_d = wdata_in[INT_W-1:0];
            default: ;
         endcase
      end
      if (rd_in)
      begin
         case (addr_in)
            CTRL_OFS: rdata_d = {26'h000_0000, ctrl_q};
            STAT_OFS: rdata_d = {30'h0000_0000, dir_q, err_q};
            POS_OFS: rdata_d = pos_q;
            MAXPOS_OFS: rdata_d = maxpos_q;
            LOAD_OFS: rdata_d = load_q;
            TIME_OFS: rdata_d = timer_q;
            COUNT_OFS: rdata_d = count_q;
            SPEED_OFS: rdata_d = speed_q;
            INTEN_OFS: rdata_d = {28'h000_0000, inten_q};
            RIS_OFS: rdata_d = {28'h000_0000, ris};
            ISC_OFS: rdata_d = {28'h000_0000, ris & inten_q};
            PREDIV_OFS: rdata_d = prediv_q;
            default: rdata_d = ZERO32;
         endcase
      end
   end

   // Register file flops
   always_ff @(posedge sys_clk_in)
   begin
      if (!reset_n_in)
      begin
         ctrl_q <= '0;
         maxpos_q <= MAXPOS_RST;
         load_q <= LOAD_RST;
         prediv_q <= ZERO32;
         inten_q <= '0;
         rdata_q <= ZERO32;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         maxpos_q <= maxpos_d;
         load_q <= load_d;
         prediv_q <= prediv_d;
         inten_q <= inten_d;
         rdata_q <= rdata_d;
      end
   end

   assign rdata_out = rdata_q;
endmodule
`default_nettype wire

// [bench/quadrature_decoder_properties.sv]
// Concurrent checks on the decoder register port and interrupt line
`default_nettype none
module quadrature_decoder_properties
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // Encoder pins
   input wire logic cha_in,
   input wire logic chb_in,
   input wire logic index_in,
   // Register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [31:0] rdata_out,
   input wire logic irq_out
);
   import quadrature_decoder_pkg::*;
   // ****************************
   // Shadow of the mask and checks
   // ****************************
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   logic [3:0] mask_d;
   logic [3:0] mask_q;
   // Next value of the mask shadow
   always_comb
   begin
      mask_d = mask_q;
      if (!reset_n_in)
         mask_d = 4'h0;
      else if (wr_in && addr_in == INTEN_OFS)
         mask_d = wdata_in[3:0];
   end
   // Register the mask shadow
   always_ff @(posedge sys_clk_in)
      mask_q <= mask_d;
   a_read_idle_zero: assert property (!rd_in |=> rdata_out == ZERO32)
      else $error("read data not zero outside a read");
   a_unmapped_read_zero: assert property (rd_in && addr_in > PREDIV_OFS |=> rdata_out == ZERO32)
      else $error("unmapped read not zero");
   a_ctrl_read_fields: assert property (rd_in && addr_in == CTRL_OFS |=> rdata_out[31:CTRL_W] == '0)
      else $error("control read has stray bits");
   a_stat_read_fields: assert property (rd_in && addr_in == STAT_OFS |=> rdata_out[31:2] == '0)
      else $error("status read has stray bits");
   a_raw_read_fields: assert property (rd_in && addr_in == RIS_OFS |=> rdata_out[31:INT_W] == '0)
      else $error("raw status has stray bits");
   a_masked_read_subset: assert property (rd_in && addr_in == ISC_OFS |=> (rdata_out & {28'h0, ~mask_q}) == '0)
      else $error("masked status shows a masked source");
   a_mask_gates_irq: assert property (mask_q == 4'h0 |-> !irq_out)
      else $error("interrupt with all sources masked");
   a_reset_quiet: assert property ($rose(reset_n_in) |-> !irq_out && rdata_out == ZERO32)
      else $error("outputs not cleared by reset");
   c_irq_rise: cover property ($rose(irq_out));
   c_clear_write: cover property (wr_in && addr_in == ISC_OFS);
   c_speed_read: cover property (rd_in && addr_in == SPEED_OFS);
   c_index_seen: cover property ($rose(index_in));
   c_phase_fault: cover property ($changed(cha_in) && $changed(chb_in));
endmodule
bind quadrature_decoder quadrature_decoder_properties chk_i
(
   .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .cha_in(cha_in), .chb_in(chb_in),
   .index_in(index_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .irq_out(irq_out)
);
`default_nettype wire

// [bench/encoder_model.sv]
// Behavioural rotary encoder driving both channels and the index
`default_nettype none
module encoder_model
(
   // Clock
   input wire logic clk_in,
   // Encoder pins
   output logic cha_out,
   output logic chb_out,
   output logic index_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************
   // Pin sequences
   // ****************************
   logic [1:0] ph = 2'h0;
   int hold = 8; // Cycles per level; larger makes a slow encoder
   initial {cha_out, chb_out, index_out} = 3'h0;
   // Quarter steps along 00,01,11,10, forward when fwd is high
   task automatic step(input logic fwd, input int n);
      repeat (n)
      begin
         ph = fwd ? ph + 2'h1 : ph - 2'h1;
         @(posedge clk_in);
         cha_out <= ph[1];
         chb_out <= ph[1] ^ ph[0];
         repeat (hold) @(posedge clk_in);
      end
   endtask
   // Step clock pulses with direction held on the second channel
   task automatic pulse(input logic rev, input int n);
      repeat (n)
      begin
         @(posedge clk_in);
         chb_out <= rev;
         cha_out <= 1'b0;
         repeat (hold) @(posedge clk_in);
         cha_out <= 1'b1;
         repeat (hold) @(posedge clk_in);
      end
   endtask
   // Both channels flip together, a deliberate fault
   task automatic glitch();
      @(posedge clk_in);
      cha_out <= ~cha_out;
      chb_out <= ~chb_out;
      repeat (hold) @(posedge clk_in);
   endtask
   // One index pulse
   task automatic index_pulse();
      @(posedge clk_in);
      index_out <= 1'b1;
      repeat (hold) @(posedge clk_in);
      index_out <= 1'b0;
      repeat (hold) @(posedge clk_in);
   endtask
endmodule
`default_nettype wire

// [bench/quadrature_decoder_bench.sv]
// Self-checking bench for the quadrature decoder
`default_nettype none
module quadrature_decoder_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import quadrature_decoder_pkg::*;
   // ****************************
   // Stimulus, bus tasks and scenarios
   // ****************************
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wd = ZERO32;
   logic [31:0] rdat;
   logic irq;
   logic cha;
   logic chb;
   logic idx;
   int err_count = 0;
   int num_checks = 0;
   // Clock at 50 ns period
   always #25 clk = ~clk;
   quadrature_decoder dut (.sys_clk_in(clk), .reset_n_in(rst_n), .cha_in(cha), .chb_in(chb),
      .index_in(idx), .addr_in(addr), .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdat), .irq_out(irq));
   encoder_model enc (.clk_in(clk), .cha_out(cha), .chb_out(chb), .index_out(idx));
   // Compare and count
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("FAIL %s exp %h got %h", n, e, g);
      end
   endtask
   // One-cycle write
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // One-cycle read, data taken in the following cycle
   task automatic rget(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdat;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      rget(a, v);
      chk($sformatf("reg %h", a), e, v);
   endtask
   // Poll for a timer expiry, then clear all four raw interrupt flags
   task automatic wait_tmr();
      logic [31:0] v;
      v = ZERO32;
      for (int i = 0; i < 80 && !v[INT_TIMER]; i++)
         rget(RIS_OFS, v);
      chk("timer", ONE32, {31'h0, v[INT_TIMER]});
      wreg(ISC_OFS, 32'h0000_000F);
   endtask
   task automatic t_reset();
      rreg(CTRL_OFS, ZERO32);
      rreg(MAXPOS_OFS, MAXPOS_RST);
      rreg(LOAD_OFS, LOAD_RST);
      rreg(STAT_OFS, 32'h0000_0002);
      rreg(INTEN_OFS, ZERO32);
      rreg(8'h30, ZERO32);
   endtask
   task automatic t_phase();
      wreg(MAXPOS_OFS, 32'h0000_0063);
      wreg(CTRL_OFS, ONE32);
      enc.step(1'b1, 4);
      rreg(POS_OFS, 32'h0000_0002);
      enc.step(1'b0, 4);
      rreg(POS_OFS, ZERO32);
      enc.step(1'b0, 2);
      rreg(POS_OFS, 32'h0000_0063);
      rreg(STAT_OFS, ZERO32);
      rreg(RIS_OFS, 32'h0000_0004);
   endtask
   task automatic t_both();
      wreg(CTRL_OFS, 32'h0000_0009);
      wreg(POS_OFS, ZERO32);
      enc.step(1'b1, 4);
      rreg(POS_OFS, 32'h0000_0004);
      wreg(CTRL_OFS, 32'h0000_000B);
      enc.step(1'b1, 4);
      rreg(POS_OFS, ZERO32);
      rreg(STAT_OFS, ZERO32);
   endtask
   task automatic t_clkdir();
      wreg(CTRL_OFS, 32'h0000_0005);
      wreg(POS_OFS, ZERO32);
      enc.pulse(1'b0, 3);
      rreg(POS_OFS, 32'h0000_0003);
      enc.pulse(1'b1, 1);
      rreg(POS_OFS, 32'h0000_0002);
      wreg(ISC_OFS, 32'h0000_000F);
      enc.index_pulse();
      rreg(POS_OFS, 32'h0000_0002);
      rreg(RIS_OFS, ONE32);
      wreg(CTRL_OFS, 32'h0000_0015);
      enc.index_pulse();
      rreg(POS_OFS, 32'h0000_0063);
      enc.pulse(1'b0, 2);
      rreg(POS_OFS, ONE32);
      enc.index_pulse();
      rreg(POS_OFS, ZERO32);
   endtask
   task automatic t_irq();
      wreg(CTRL_OFS, ONE32);
      wreg(ISC_OFS, 32'h0000_000F);
      enc.glitch();
      rreg(STAT_OFS, 32'h0000_0003);
      rreg(POS_OFS, ZERO32);
      rreg(RIS_OFS, 32'h0000_0008);
      rreg(ISC_OFS, ZERO32);
      chk("irq", ZERO32, {31'h0, irq});
      wreg(INTEN_OFS, 32'h0000_0008);
      @(negedge clk);
      chk("irq", ONE32, {31'h0, irq});
      repeat (20) @(posedge clk);
      rreg(ISC_OFS, 32'h0000_0008);
      wreg(STAT_OFS, ONE32);
      wreg(ISC_OFS, 32'h0000_0008);
      rreg(RIS_OFS, ZERO32);
      rreg(STAT_OFS, 32'h0000_0002);
      chk("irq", ZERO32, {31'h0, irq});
   endtask
   task automatic t_vel();
      wreg(LOAD_OFS, 32'h0000_0063);
      wreg(CTRL_OFS, 32'h0000_0025);
      wait_tmr();
      enc.pulse(1'b0, 3);
      rreg(COUNT_OFS, 32'h0000_0003);
      wait_tmr();
      rreg(SPEED_OFS, 32'h0000_0003);
      wreg(CTRL_OFS, 32'h0000_0024);
      enc.pulse(1'b0, 3);
      rreg(COUNT_OFS, ZERO32);
      rreg(TIME_OFS, 32'h0000_0063);
      wreg(PREDIV_OFS, 32'h0000_0003);
      rreg(PREDIV_OFS, 32'h0000_0003);
   endtask
   // Verdict and end of run
   task automatic results();
      $display("Checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #(6000 * 50);
      err_count++;
      results();
   end
   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_phase();
      t_both();
      t_clkdir();
      t_irq();
      t_vel();
      results();
   end
endmodule
`default_nettype wire
